// ### hw/dpsf_host.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RL1] flags live apart from the memory array
// [RL2] zero requests a token, one releases
// [RL3] token_space_select low selects flag space
// [RL4] only three low address lines pick flag
// [RL5] device takes only the lowest data bit
// [RL6] free flag written zero: writer reads zero
// [RL7] only owner changes a flag; release frees
// [RL8] locked-out zero waits in request latch
// [RL9] read copies flag onto all data bits
// [RL10] read value latched while select and enable
// [RL11] polling drops select between successive reads
// [RL12] acquire writes zero, then reads back
// [RL13] pending request takes token on release
// [RL14] failed request: retry reads or withdraw
// [RL15] simultaneous requests yield exactly one winner
// [RL16] flags undefined at power-up
// [RL17] init writes one to all flags
// [RL18] both selects high means port standby
// [RL19] both sides never own one flag
module dpsf_host
    import dpsf_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // user command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire dpsf_pkg::dpsf_cmd_e cmd_op,
    input wire logic [dpsf_pkg::DPSF_IW-1:0] cmd_flag,
    output logic rsp_valid,
    output logic rsp_granted,
    output logic rsp_flag_value,
    // device pins, one port
    output logic array_select_n,
    output logic token_space_select_n,
    output logic rd_wr_n,
    output logic out_enable_n,
    output logic [dpsf_pkg::DPSF_AW-1:0] addr,
    output logic [dpsf_pkg::DPSF_DW-1:0] data_out,
    output logic data_oe,
    input wire logic [dpsf_pkg::DPSF_DW-1:0] data_in
);
    import dpsf_pkg::*;

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DPSF_IDLE,
        DPSF_WSETUP,
        DPSF_WPULSE,
        DPSF_GAP,
        DPSF_READ,
        DPSF_DONE
    } dpsf_state_e;

    dpsf_state_e state_reg, state_next;
    logic [DPSF_CW-1:0] cnt_reg, cnt_next;    // phase counter
    dpsf_cmd_e op_reg;                        // command in progress
    logic [DPSF_IW-1:0] idx_reg;              // flag being worked on
    logic wval_reg;                           // value to write
    logic rval_reg;                           // value read back
    logic rsp_valid_reg;                      // answer strobe
    logic rsp_granted_reg;                    // acquire outcome
    logic [DPSF_DW-1:0] din_sync;             // synchronised data pins

    // ------------------------------------------------------------
    // data pins come from the device, outside our clock
    // ------------------------------------------------------------
    dpsf_sync #(.W(DPSF_DW)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(data_in),
        .sync_out(din_sync)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // true when the command begins with a write
    function automatic logic op_writes(input dpsf_cmd_e op);
        op_writes = (op != DPSF_CMD_POLL);
    endfunction
    // value driven on the write for each command; release withdraws a failed request [RL14]
    function automatic logic op_value(input dpsf_cmd_e op);
        op_value = (op == DPSF_CMD_ACQUIRE) ? DPSF_TAKE : DPSF_FREE; // [RL2]
    endfunction

    wire take_cmd = cmd_valid && cmd_ready;
    wire cnt_done = (cnt_reg == '0);
    wire last_flag = (idx_reg == DPSF_IW'(DPSF_NFLAG - 1));
    wire read_bit = din_sync[DPSF_VAL_BIT]; // [RL9] every bit carries the flag
    wire in_write = (state_reg == DPSF_WSETUP) || (state_reg == DPSF_WPULSE);
    wire in_read = (state_reg == DPSF_READ);

    assign cmd_ready = (state_reg == DPSF_IDLE);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            DPSF_IDLE: begin
                if (take_cmd) begin
                    if (op_writes(cmd_op)) begin
                        state_next = DPSF_WSETUP;
                        cnt_next = DPSF_CW'(1);
                    end else begin
                        state_next = DPSF_READ; // poll reads only
                        cnt_next = DPSF_CW'(DPSF_ACC_CYC + DPSF_SYNC_CYC);
                    end
                end
            end
            DPSF_WSETUP: begin
                // address and data settle before the strobe
                state_next = DPSF_WPULSE;
                cnt_next = DPSF_CW'(DPSF_WP_CYC - 1);
            end
            DPSF_WPULSE: begin
                if (cnt_done) begin
                    state_next = DPSF_GAP;
                    cnt_next = DPSF_CW'(DPSF_GAP_CYC - 1);
                end else begin
                    cnt_next = cnt_reg - DPSF_CW'(1);
                end
            end
            DPSF_GAP: begin
                // select off between cycles so the next read relatches [RL11]
                if (!cnt_done) begin
                    cnt_next = cnt_reg - DPSF_CW'(1);
                end else if (op_reg == DPSF_CMD_ACQUIRE) begin
                    state_next = DPSF_READ; // write then read back [RL12]
                    cnt_next = DPSF_CW'(DPSF_ACC_CYC + DPSF_SYNC_CYC);
                end else if (op_reg == DPSF_CMD_INIT && !last_flag) begin
                    state_next = DPSF_WSETUP; // next flag [RL17]
                    cnt_next = DPSF_CW'(1);
                end else begin
                    state_next = DPSF_DONE;
                end
            end
            DPSF_READ: begin
                // access time plus synchroniser depth before sampling
                if (cnt_done) begin
                    state_next = DPSF_DONE;
                end else begin
                    cnt_next = cnt_reg - DPSF_CW'(1);
                end
            end
            DPSF_DONE: begin
                state_next = DPSF_IDLE;
            end
            default: begin
                state_next = DPSF_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= DPSF_IDLE;
            cnt_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ------------------------------------------------------------
    // command capture and flag index walk
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            op_reg <= DPSF_CMD_POLL;
            idx_reg <= '0;
            wval_reg <= DPSF_FREE;
        end else if (clk_en) begin
            if (take_cmd) begin
                op_reg <= cmd_op;
                idx_reg <= (cmd_op == DPSF_CMD_INIT) ? '0 : cmd_flag; // [RL17]
                wval_reg <= op_value(cmd_op);
            end else if (state_reg == DPSF_GAP && cnt_done
                         && op_reg == DPSF_CMD_INIT && !last_flag) begin
                idx_reg <= idx_reg + DPSF_IW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // read sampling and answer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rval_reg <= DPSF_FREE;
            rsp_valid_reg <= 1'b0;
            rsp_granted_reg <= 1'b0;
        end else if (clk_en) begin
            rsp_valid_reg <= (state_next == DPSF_DONE);
            if (in_read && cnt_done) begin
                rval_reg <= read_bit;
                // zero read back means this side owns it [RL12] [RL19]
                rsp_granted_reg <= (op_reg == DPSF_CMD_ACQUIRE) && (read_bit == DPSF_TAKE);
            end else if (take_cmd) begin
                rsp_granted_reg <= 1'b0;
            end
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_granted = rsp_granted_reg;
    assign rsp_flag_value = rval_reg;

    // ------------------------------------------------------------
    // device pins
    // ------------------------------------------------------------
    // the array is never selected; flag space only [RL1] [RL18]
    assign array_select_n = 1'b1;
    assign token_space_select_n = !(in_write || in_read); // [RL3] [RL11]
    assign rd_wr_n = !(state_reg == DPSF_WPULSE);
    assign out_enable_n = !in_read; // [RL10]
    // flag index on the low lines, upper lines held at zero [RL4]
    assign addr = {{(DPSF_AW - DPSF_IW){1'b0}}, idx_reg};
    // write value on the lowest bit, copied everywhere [RL5]
    assign data_out = {DPSF_DW{wval_reg}};
    assign data_oe = in_write;
endmodule
`default_nettype wire

// ### hw/dpsf_pkg.sv
package dpsf_pkg;
    // ------------------------------------------------------------
    // widths of the device's port
    // ------------------------------------------------------------
    localparam int DPSF_AW = 13;    // address lines of one port
    localparam int DPSF_DW = 16;    // data lines of one port
    localparam int DPSF_NFLAG = 8;  // number of token latches
    localparam int DPSF_IW = 3;     // width of flag_index_lines
    localparam int DPSF_VAL_BIT = 0; // position of flag_value_bit
    // ------------------------------------------------------------
    // flag encodings, active low
    // ------------------------------------------------------------
    localparam logic DPSF_TAKE = 1'b0; // request or owned
    localparam logic DPSF_FREE = 1'b1; // release or free
    // ------------------------------------------------------------
    // bus timing in sys_clk cycles (5 ns each)
    // ------------------------------------------------------------
    localparam int DPSF_CLK_PS = 5000;        // clock period in ps
    localparam int DPSF_T_ACC_PS = 45000;     // access time, slow grade
    localparam int DPSF_T_WP_PS = 40000;      // write pulse width
    localparam int DPSF_T_GAP_PS = 15000;     // idle between cycles
    localparam int DPSF_ACC_CYC = (DPSF_T_ACC_PS + DPSF_CLK_PS - 1) / DPSF_CLK_PS;
    localparam int DPSF_WP_CYC = (DPSF_T_WP_PS + DPSF_CLK_PS - 1) / DPSF_CLK_PS;
    localparam int DPSF_GAP_CYC = (DPSF_T_GAP_PS + DPSF_CLK_PS - 1) / DPSF_CLK_PS;
    localparam int DPSF_CW = 4;               // width of the phase counter
    localparam int DPSF_SYNC_CYC = 3;         // extra read cycles for the data synchroniser
    // ------------------------------------------------------------
    // commands from the user side
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPSF_CMD_ACQUIRE,   // write zero then read back
        DPSF_CMD_RELEASE,   // write one
        DPSF_CMD_POLL,      // read only
        DPSF_CMD_INIT       // write one to every flag
    } dpsf_cmd_e;
endpackage

// ### hw/dpsf_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three stage input synchroniser, change taken when stages 2 and 3 agree
module dpsf_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_reg; // first stage, read only by s2
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);
    // ------------------------------------------------------------
    // shift chain and filtered output
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else if (clk_en) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= (agree & s3_reg) | (~agree & out_reg);
        end
    end
    assign sync_out = out_reg;
endmodule
`default_nettype wire

// ### bench/dpsf_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// token latch device, one host port plus far port
// ----------------------------------------
module dpsf_dev_model
    import dpsf_pkg::*;
(
    // host side pins
    input wire logic sem_n,
    input wire logic rd_wr_n,
    input wire logic oe_n,
    input wire logic [dpsf_pkg::DPSF_AW-1:0] addr,
    input wire logic [dpsf_pkg::DPSF_DW-1:0] data_out,
    output logic [dpsf_pkg::DPSF_DW-1:0] data_in
);
    int own [DPSF_NFLAG]; // one owner code per flag: 0 free, 1 host, 2 far
    logic req_h [DPSF_NFLAG]; // host request latches
    logic req_o [DPSF_NFLAG]; // far request latches
    logic rd_q; // host read output register
    // arbitrary power-up contents, far port holds all
    initial begin
        for (int i = 0; i < DPSF_NFLAG; i++) begin
            own[i] = 2;
            req_h[i] = 1'b0;
            req_o[i] = 1'b0;
        end
        rd_q = 1'b1;
    end
    // release by owner, then hand to any pending side, first come wins
    function automatic void settle(input int i);
        if (own[i] == 1 && req_h[i]) own[i] = 0;
        if (own[i] == 2 && req_o[i]) own[i] = 0;
        if (own[i] == 0 && !req_h[i]) own[i] = 1;
        else if (own[i] == 0 && !req_o[i]) own[i] = 2;
    endfunction
    // far port write and read, called by the bench
    task automatic far_write(input int i, input logic v);
        req_o[i] = v;
        settle(i);
    endtask
    function automatic logic far_read(input int i);
        return own[i] != 2;
    endfunction
    // host write: low index lines and bit zero only
    always @(negedge rd_wr_n) begin
        if (!sem_n) begin
            req_h[addr[2:0]] = data_out[DPSF_VAL_BIT];
            settle(int'(addr[2:0]));
        end
    end
    // value frozen when select and enable go active
    always @(negedge (sem_n | oe_n)) rd_q = (own[addr[2:0]] != 1);
    // flag copied to all bits; inverse when not driven
    assign data_in = (!sem_n && !oe_n) ? {DPSF_DW{rd_q}} : {DPSF_DW{~rd_q}};
endmodule
`default_nettype wire

// ### bench/dpsf_host_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// pin sequencing checks of the host
// ----------------------------------------
module dpsf_host_asserts
    import dpsf_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // handshake
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    // device pins
    input wire logic array_select_n,
    input wire logic token_space_select_n,
    input wire logic rd_wr_n,
    input wire logic out_enable_n,
    input wire logic [dpsf_pkg::DPSF_AW-1:0] addr,
    input wire logic [dpsf_pkg::DPSF_DW-1:0] data_out,
    input wire logic data_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_array_unused: assert property (array_select_n)
        else $error("array select driven");
    chk_flag_index: assert property (!token_space_select_n |-> addr[12:3] == 10'h000)
        else $error("upper address lines set");
    chk_write_qual: assert property (!rd_wr_n |-> !token_space_select_n && data_oe && out_enable_n)
        else $error("write pulse without select");
    chk_data_repl: assert property (data_oe |-> data_out == {DPSF_DW{data_out[0]}})
        else $error("write value not replicated");
    chk_pulse_len: assert property ($fell(rd_wr_n) |-> (!rd_wr_n)[*8] ##1 rd_wr_n)
        else $error("write pulse length wrong");
    chk_read_hold: assert property ($fell(out_enable_n) |-> (!out_enable_n && !token_space_select_n)[*8])
        else $error("read dropped early");
    chk_read_end: assert property ($fell(out_enable_n) |-> ##[9:16] (out_enable_n && token_space_select_n))
        else $error("read not closed");
    chk_standby_quiet: assert property (token_space_select_n |-> out_enable_n && rd_wr_n && !data_oe)
        else $error("activity in standby");
    chk_done_idle: assert property (rsp_valid |-> token_space_select_n ##1 cmd_ready)
        else $error("done without idle");
endmodule
bind dpsf_host dpsf_host_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .array_select_n(array_select_n), .rd_wr_n(rd_wr_n),
    .token_space_select_n(token_space_select_n), .out_enable_n(out_enable_n), .addr(addr),
    .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dpsf_pkg::*;
    logic sys_clk, rst_n, clk_en, cmd_valid, cmd_ready, rsp_valid, rsp_granted, rsp_flag_value;
    logic array_select_n, token_space_select_n, rd_wr_n, out_enable_n, data_oe;
    dpsf_cmd_e cmd_op;
    logic [DPSF_IW-1:0] cmd_flag;
    logic [DPSF_AW-1:0] addr;
    logic [DPSF_DW-1:0] data_out, data_in;
    int err_count = 0;
    int comparisons = 0;
    dpsf_host u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_flag(cmd_flag), .rsp_valid(rsp_valid),
        .rsp_granted(rsp_granted), .rsp_flag_value(rsp_flag_value), .addr(addr),
        .array_select_n(array_select_n), .token_space_select_n(token_space_select_n),
        .rd_wr_n(rd_wr_n), .out_enable_n(out_enable_n), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in));
    dpsf_dev_model u_dev (.sem_n(token_space_select_n), .rd_wr_n(rd_wr_n),
        .oe_n(out_enable_n), .addr(addr), .data_out(data_out), .data_in(data_in));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %b want %b", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one command, held until taken, then wait for its response
    task automatic issue(input dpsf_cmd_e op, input int f);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        cmd_op = op;
        cmd_flag = f[2:0];
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n == 200) begin
            err_count++;
            $display("ERROR %0t: no response", $time);
        end
    endtask
    // both ports clear every latch, then all flags read free
    task automatic s_init;
        issue(DPSF_CMD_INIT, 0);
        for (int i = 0; i < 8; i++) u_dev.far_write(i, 1'b1);
        for (int i = 0; i < 8; i++) begin
            issue(DPSF_CMD_POLL, i);
            check1(rsp_flag_value, 1'b1);
        end
    endtask
    // every flag taken and given back in turn
    task automatic s_each;
        for (int i = 0; i < 8; i++) begin
            issue(DPSF_CMD_ACQUIRE, i);
            check1(rsp_granted, 1'b1);
            issue(DPSF_CMD_RELEASE, i);
            check1(u_dev.far_read(i), 1'b1);
        end
    endtask
    // far port waits behind the host, then host is locked out
    task automatic s_handover;
        issue(DPSF_CMD_ACQUIRE, 3);
        u_dev.far_write(3, 1'b0);
        issue(DPSF_CMD_RELEASE, 3);
        check1(u_dev.far_read(3), 1'b0);
        issue(DPSF_CMD_ACQUIRE, 3);
        check1(rsp_granted, 1'b0);
        check1(rsp_flag_value, 1'b1);
        issue(DPSF_CMD_RELEASE, 3);
        u_dev.far_write(3, 1'b1);
        issue(DPSF_CMD_POLL, 3);
        check1(rsp_flag_value, 1'b1);
    endtask
    // failed request left pending, then token arrives on a later poll
    task automatic s_late;
        u_dev.far_write(5, 1'b0);
        issue(DPSF_CMD_ACQUIRE, 5);
        check1(rsp_granted, 1'b0);
        u_dev.far_write(5, 1'b1);
        issue(DPSF_CMD_POLL, 5);
        check1(rsp_flag_value, 1'b0);
        issue(DPSF_CMD_RELEASE, 5);
        issue(DPSF_CMD_POLL, 5);
        check1(rsp_flag_value, 1'b1);
    endtask
    // clock enable low: a waiting command is not taken and the pins stay idle
    task automatic s_freeze;
        @(posedge sys_clk);
        #1 clk_en = 1'b0;
        cmd_op = DPSF_CMD_POLL;
        cmd_flag = 3'h2;
        cmd_valid = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 check1(token_space_select_n, 1'b1);
        check1(rsp_valid, 1'b0);
        check1(cmd_ready, 1'b1);
        cmd_valid = 1'b0;
        @(posedge sys_clk);
        #1 clk_en = 1'b1;
        issue(DPSF_CMD_POLL, 2);
        check1(rsp_flag_value, 1'b1);
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = DPSF_CMD_POLL;
        cmd_flag = 3'h0;
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        s_init();
        s_each();
        s_handover();
        s_late();
        s_freeze();
        end_of_test();
    end
    // watchdog against a hang
    initial begin
        #40000;
        err_count++;
        $display("ERROR %0t: timeout", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
